// ---- rtl/pcl_level_decode.sv ----
// module: decodes a latched pulse level index to a feedback reference in mV
`timescale 1ns/10ps
module pcl_level_decode (
  input wire logic [2:0] level,                     // 0 = one pulse, 7 = eight or more
  output logic [pcl_pkg::REF_W-1:0] ref_mv          // torch reference
);
  always_comb begin
    case (level)
      3'h0: ref_mv = pcl_pkg::REF_LV1;
      3'h1: ref_mv = pcl_pkg::REF_LV2;
      3'h2: ref_mv = pcl_pkg::REF_LV3;
      3'h3: ref_mv = pcl_pkg::REF_LV4;
      3'h4: ref_mv = pcl_pkg::REF_LV5;
      3'h5: ref_mv = pcl_pkg::REF_LV6;
      3'h6: ref_mv = pcl_pkg::REF_LV7;
      default: ref_mv = pcl_pkg::REF_LV8;
    endcase
  end
endmodule

// ---- rtl/pcl_pkg.sv ----
// package: constants and carrier types for the pulse count level select block
package pcl_pkg;
  localparam int CLK_MHZ = 250;
  localparam int LATCH_HOLD_TIME_US = 500;
  localparam int SHUTDOWN_TIME_US = 500;
  localparam int LATCH_HOLD_CYC = LATCH_HOLD_TIME_US * CLK_MHZ;
  localparam int SHUTDOWN_CYC = SHUTDOWN_TIME_US * CLK_MHZ;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'h8;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam int REF_W = 10;
  // torch references in mV, index is the pulse count, level index plus one
  localparam logic [REF_W-1:0] REF_LV1 = 10'h032;
  localparam logic [REF_W-1:0] REF_LV2 = 10'h03c;
  localparam logic [REF_W-1:0] REF_LV3 = 10'h046;
  localparam logic [REF_W-1:0] REF_LV4 = 10'h055;
  localparam logic [REF_W-1:0] REF_LV5 = 10'h064;
  localparam logic [REF_W-1:0] REF_LV6 = 10'h078;
  localparam logic [REF_W-1:0] REF_LV7 = 10'h08c;
  localparam logic [REF_W-1:0] REF_LV8 = 10'h0aa;
  localparam logic [2:0] LVL_RST = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_COUNT = 3'b010,
    ST_RUN   = 3'b100
  } pcl_state_type;

  typedef struct packed {
    logic active;
    logic flash_mode;
    logic boost_en;
    logic [REF_W-1:0] ref_mv;
  } pcl_out_type;
endpackage

// ---- rtl/pcl_top.sv ----
// module: enable-pin pulse count control, mode select, shutdown and boost request
//
// Summary of operation
// - flash-select high: flash mode, reference from flash level resistor input.
// - flash-select low: torch mode, reference from received pulse count.
// - count rising enable edges in torch mode, decode into eight levels.
// - counts 1..7 give 50,60,70,85,100,120,140 mV; eight or more 170 mV.
// - enable low for the shutdown time shuts the device down.
// - over-temperature forces shutdown until temperature falls back.
// - boost enabled whenever output is active and feedback is below the selected reference.
// - latch timeout is 500 us.
// - shutdown timeout is 500 us.
`timescale 1ns/10ps
module pcl_top #(
  parameter int LATCH_CYC = pcl_pkg::LATCH_HOLD_CYC,   // enable-high cycles before latch
  parameter int SHUT_CYC = pcl_pkg::SHUTDOWN_CYC      // enable-low cycles before shutdown
) (
  input wire logic ref_clk,                                  // 250 MHz clock
  input wire logic nrst,                                     // async reset, active low
  input wire logic enable_in,                                // enable / pulse pin
  input wire logic flash_sel,                                // high = flash, low = torch
  input wire logic over_temp,                                // die above thermal limit
  input wire logic [pcl_pkg::REF_W-1:0] flash_level_resistor, // flash reference, mV
  input wire logic [pcl_pkg::REF_W-1:0] fb_mv,               // sensed feedback, mV
  output pcl_pkg::pcl_out_type out_r                         // registered outputs
);
  localparam int TW = 20;
  localparam logic [TW-1:0] LATCH_LIM = TW'(LATCH_CYC - 1);
  localparam logic [TW-1:0] SHUT_LIM = TW'(SHUT_CYC - 1);

  pcl_pkg::pcl_state_type state_r;
  logic en_d_r;
  logic [TW-1:0] hi_cnt_r;
  logic [TW-1:0] lo_cnt_r;
  logic [pcl_pkg::CNT_W-1:0] pulse_cnt_r;
  logic [2:0] level_r;
  logic level_valid_r;
  logic [pcl_pkg::REF_W-1:0] torch_ref;
  logic [pcl_pkg::REF_W-1:0] sel_ref;
  logic rise;
  logic latch_hit;
  logic shut_hit;

  assign rise = enable_in & ~en_d_r;
  assign latch_hit = enable_in && hi_cnt_r == LATCH_LIM;
  assign shut_hit = !enable_in && lo_cnt_r == SHUT_LIM;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= enable_in;
    end
  end

  // timers saturate so a long level fires its event only once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
    end else begin
      if (!enable_in) begin
        hi_cnt_r <= '0;
      end else if (hi_cnt_r != LATCH_LIM + TW'(1)) begin
        hi_cnt_r <= hi_cnt_r + TW'(1);
      end
      if (enable_in) begin
        lo_cnt_r <= '0;
      end else if (lo_cnt_r != SHUT_LIM + TW'(1)) begin
        lo_cnt_r <= lo_cnt_r + TW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= pcl_pkg::ST_OFF;
    end else begin
      case (state_r)
        pcl_pkg::ST_OFF: begin
          if (rise) begin
            state_r <= pcl_pkg::ST_COUNT;
          end
        end
        pcl_pkg::ST_COUNT: begin
          if (shut_hit) begin
            state_r <= pcl_pkg::ST_OFF;
          end else if (latch_hit) begin
            state_r <= pcl_pkg::ST_RUN;
          end
        end
        pcl_pkg::ST_RUN: begin
          if (shut_hit) begin
            state_r <= pcl_pkg::ST_OFF;
          end else if (rise && !flash_sel) begin
            state_r <= pcl_pkg::ST_COUNT;
          end
        end
        default: state_r <= pcl_pkg::ST_OFF;
      endcase
    end
  end

  // counting only in torch mode; flash mode ignores pulses
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_r <= pcl_pkg::CNT_RST;
    end else if (shut_hit) begin
      pulse_cnt_r <= pcl_pkg::CNT_RST;
    end else if (latch_hit && state_r == pcl_pkg::ST_COUNT) begin
      pulse_cnt_r <= pcl_pkg::CNT_RST;
    end else if (rise && !flash_sel && pulse_cnt_r != pcl_pkg::CNT_MAX) begin
      pulse_cnt_r <= pulse_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      level_r <= pcl_pkg::LVL_RST;
      level_valid_r <= 1'b0;
    end else if (shut_hit) begin
      level_r <= pcl_pkg::LVL_RST;
      level_valid_r <= 1'b0;
    end else if (latch_hit && state_r == pcl_pkg::ST_COUNT && pulse_cnt_r != pcl_pkg::CNT_RST) begin
      level_r <= 3'(pulse_cnt_r - 4'h1);
      level_valid_r <= 1'b1;
    end
  end

  pcl_level_decode u_dec (
    .level(level_r),
    .ref_mv(torch_ref)
  );

  // flash always uses resistor reference; torch needs a latched level
  assign sel_ref = flash_sel ? flash_level_resistor : torch_ref;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_r <= '0;
    end else begin
      out_r.flash_mode <= flash_sel;
      out_r.ref_mv <= sel_ref;
      // over-temp gates operation only while it lasts
      out_r.active <= state_r != pcl_pkg::ST_OFF && !over_temp
                      && (flash_sel || level_valid_r);
      out_r.boost_en <= state_r != pcl_pkg::ST_OFF && !over_temp
                        && (flash_sel || level_valid_r) && fb_mv < sel_ref;
    end
  end
endmodule

// ---- tb/pcl_asserts.sv ----
// checker: port relations of the pulse count block
`timescale 1ns/10ps
module pcl_asserts #(
  parameter int LATCH_CYC = 20,
  parameter int SHUT_CYC = 20
) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic enable_in, // pin
  input wire logic flash_sel, // mode
  input wire logic over_temp, // hot
  input wire logic [pcl_pkg::REF_W-1:0] flash_level_resistor, // flash ref
  input wire logic [pcl_pkg::REF_W-1:0] fb_mv, // feedback
  input wire pcl_pkg::pcl_out_type out_r // outputs
);
  int hi_n;
  int lo_n;
  // run lengths of the pin, high and low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_n <= 0;
      lo_n <= 0;
    end else begin
      hi_n <= enable_in ? hi_n + 1 : 0;
      lo_n <= enable_in ? 0 : lo_n + 1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ot; over_temp |=> !out_r.active && !out_r.boost_en; endproperty
  a_ot: assert property (p_ot) else $error("running while hot");
  property p_fm; flash_sel |=> out_r.flash_mode; endproperty
  a_fm: assert property (p_fm) else $error("flash mode missing");
  property p_fref; flash_sel ##1 out_r.active |-> out_r.ref_mv == $past(flash_level_resistor); endproperty
  a_fref: assert property (p_fref) else $error("flash ref wrong");
  property p_bact; out_r.boost_en |-> out_r.active; endproperty
  a_bact: assert property (p_bact) else $error("boost while off");
  property p_boost; out_r.active && $past(out_r.active) && $stable(fb_mv) && $stable(out_r.ref_mv)
    |-> out_r.boost_en == (fb_mv < out_r.ref_mv); endproperty
  a_boost: assert property (p_boost) else $error("boost wrong");
  property p_shut; lo_n == SHUT_CYC + 2 |-> !out_r.active; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_early; $fell(out_r.active) |-> $past(over_temp) || $changed(out_r.flash_mode)
    || lo_n >= SHUT_CYC - 1; endproperty
  a_early: assert property (p_early) else $error("early shutdown");
  property p_lat; hi_n == LATCH_CYC + 2 && !over_temp && !$past(over_temp) |-> out_r.active; endproperty
  a_lat: assert property (p_lat) else $error("no latch");
  c_lat: cover property (hi_n == LATCH_CYC + 2 && out_r.active);
  c_shut: cover property ($fell(out_r.active));
  c_flash: cover property (out_r.flash_mode && out_r.active);
endmodule
bind pcl_top pcl_asserts #(.LATCH_CYC(LATCH_CYC), .SHUT_CYC(SHUT_CYC)) pcl_asserts_i (.ref_clk(ref_clk),
  .nrst(nrst), .enable_in(enable_in), .flash_sel(flash_sel), .over_temp(over_temp),
  .flash_level_resistor(flash_level_resistor), .fb_mv(fb_mv), .out_r(out_r));

// ---- tb/pcl_host.sv ----
// host model: enable pulse trains and shutdown holds
`timescale 1ns/10ps
module pcl_host #(
  parameter int LATCH_CYC = 20,
  parameter int SHUT_CYC = 20
) (
  input wire logic ref_clk, // clock
  output logic enable_in // pin
);
  initial enable_in = 1'b0;
  // gaps and pulses kept far below both timeouts
  task automatic train(input int n);
    for (int i = 0; i < n; i++) begin
      enable_in = 1'b0;
      repeat (3) @(negedge ref_clk);
      enable_in = 1'b1;
      repeat (3) @(negedge ref_clk);
    end
    repeat (LATCH_CYC) @(negedge ref_clk);
  endtask
  task automatic shut();
    enable_in = 1'b0;
    repeat (SHUT_CYC + 6) @(negedge ref_clk);
  endtask
endmodule

// ---- tb/tb_top.sv ----
// bench: level trains, shutdown, boost, thermal, flash
`timescale 1ns/10ps
module tb_top;
  localparam int LAT = 20;
  logic ref_clk, nrst, flash_sel, over_temp, enable_in;
  logic [9:0] flash_level_resistor, fb_mv;
  pcl_pkg::pcl_out_type out_r;
  int error_cnt = 0, compares = 0, cyc = 0;
  logic [9:0] lv [8] = '{10'h032, 10'h03c, 10'h046, 10'h055, 10'h064, 10'h078, 10'h08c, 10'h0aa};
  pcl_host #(.LATCH_CYC(LAT), .SHUT_CYC(LAT)) pcl_host_i (.ref_clk(ref_clk), .enable_in(enable_in));
  pcl_top #(.LATCH_CYC(LAT), .SHUT_CYC(LAT)) pcl_top_i (.ref_clk(ref_clk), .nrst(nrst), .enable_in(enable_in),
    .flash_sel(flash_sel), .over_temp(over_temp), .flash_level_resistor(flash_level_resistor),
    .fb_mv(fb_mv), .out_r(out_r));
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cf(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cl(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic w3();
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic t_levels();
    for (int n = 1; n <= 9; n++) begin
      pcl_host_i.train(n);
      cf("active", 1'b1, out_r.active);
      cf("flash", 1'b0, out_r.flash_mode);
      cl("ref", lv[(n > 8 ? 8 : n) - 1], out_r.ref_mv);
    end
  endtask
  task automatic t_shut();
    pcl_host_i.train(3);
    pcl_host_i.shut();
    cf("active", 1'b0, out_r.active);
    pcl_host_i.train(2);
    cl("ref", lv[1], out_r.ref_mv);
  endtask
  task automatic t_boost();
    fb_mv = 10'h03b;
    w3();
    cf("boost", 1'b1, out_r.boost_en);
    fb_mv = 10'h03c;
    w3();
    cf("boost", 1'b0, out_r.boost_en);
  endtask
  task automatic t_temp();
    fb_mv = 10'h000;
    over_temp = 1'b1;
    w3();
    cf("active", 1'b0, out_r.active);
    cf("boost", 1'b0, out_r.boost_en);
    over_temp = 1'b0;
    w3();
    cf("active", 1'b1, out_r.active);
  endtask
  task automatic t_flash();
    flash_sel = 1'b1;
    w3();
    cl("ref", 10'h09e, out_r.ref_mv);
    pcl_host_i.train(3);
    cl("ref", 10'h09e, out_r.ref_mv);
    cf("flash", 1'b1, out_r.flash_mode);
    flash_sel = 1'b0;
    w3();
    cl("ref", lv[1], out_r.ref_mv);
  endtask
  initial begin
    nrst = 0;
    flash_sel = 0;
    over_temp = 0;
    flash_level_resistor = 10'h09e;
    fb_mv = 10'h3ff;
    repeat (16) @(negedge ref_clk);
    nrst = 1;
    t_levels();
    t_shut();
    t_boost();
    t_temp();
    t_flash();
    test_done();
  end
endmodule
